// ---- scr_pkg.sv ----
// Purpose: Constants for the serial interface configuration register bank
// Assumes: 8-bit registers on a byte-wide register port
// Notes: Part class code value is arbitrary
package scr_pkg;
  localparam int ADDR_W = 15;
  localparam int DATA_W = 8;
  localparam logic [ADDR_W-1:0] OFS_INTERFACE_CONFIG = 15'h0000;
  localparam logic [ADDR_W-1:0] OFS_OPERATING_STATE = 15'h0002;
  localparam logic [ADDR_W-1:0] OFS_PART_CLASS = 15'h0003;
  localparam int BIT_FULL_RESET = 7;
  localparam int BIT_ADDR_UP = 5;
  localparam int BIT_SEP_OUT = 4;
  localparam int MODE_LSB = 0;
  localparam int MODE_W = 2;
  localparam logic [7:0] RST_INTERFACE_CONFIG = 8'h30;
  localparam logic [7:0] RST_OPERATING_STATE = 8'h00;
  localparam logic [7:0] RST_PART_CLASS_HI = 8'h00;
  // Arbitrary class code
  localparam logic [3:0] PART_CLASS_CODE = 4'h5;
  localparam logic [1:0] MODE_NORMAL = 2'h0;
  localparam logic [1:0] MODE_POWER_DOWN = 2'h3;
  localparam int CLK_PERIOD_NS = 10;
  localparam int RESET_TIME_NS = 750;
  localparam int RESET_CYCLES = RESET_TIME_NS / CLK_PERIOD_NS;
  localparam logic [7:0] MASK_CFG_RW = 8'h6f;
  localparam logic [7:0] MASK_PART_RW = 8'hf0;
  localparam logic [7:0] ZERO_BYTE = 8'h00;
endpackage

// ---- scr_if.sv ----
// Purpose: Carrier between the bank and its reset timer
// Assumes: Single clock
// Notes: Start is a one-cycle pulse
`timescale 1ns/10ps
`default_nettype none
interface scr_if;
  logic start;
  logic busy;
  modport bank (output start, input busy);
  modport timer (input start, output busy);
endinterface
`default_nettype wire

// ---- scr_reset_timer.sv ----
// Purpose: Holds the internal reset for the full-chip reset interval
// Assumes: Start is synchronous to clk_i
// Notes: A restart while busy reloads the count
`timescale 1ns/10ps
`default_nettype none
module scr_reset_timer #(
  parameter int CYCLES = scr_pkg::RESET_CYCLES
) (
  // Clock and reset
  input wire logic clk_i,
  input wire logic rst_n,
  // Control
  scr_if.timer ctl
);
  import scr_pkg::*;
  localparam int CW = $clog2(CYCLES + 1);
  logic [CW-1:0] cnt_reg;
  always_ff @(posedge clk_i or negedge rst_n) begin
    if (!rst_n) begin
      cnt_reg <= '0;
    end else if (ctl.start) begin
      cnt_reg <= CW'(CYCLES);
    end else if (cnt_reg != '0) begin
      cnt_reg <= cnt_reg - CW'(1);
    end
  end
  assign ctl.busy = (cnt_reg != '0);
endmodule
`default_nettype wire

// ---- scr_regs.sv ----
// Purpose: Interface configuration, operating state and part class registers
// Assumes: Serial framing decodes address, write strobe and read strobe
// Notes: Full-chip reset held internally for the whole reset interval
//
// Behaviour
// RQ1: Writing one to bit 7 resets the whole chip and this register.
// RQ2: The full-chip reset bit clears itself when the reset completes.
// RQ3: Host waits up to 750 ns after a full reset before transacting.
// RQ4: Bit 5 picks streaming address direction; 1 increments, resets to 1.
// RQ5: Bit 4 reads one always; reads use the separate output line.
// RQ6: Mode bits 1:0: 0 normal, 3 power down, 1 and 2 reserved.
// RQ7: Interface configuration register reads 0x30 after reset.
// RQ8: Reserved bits reset to zero and hold writes; read-only writes ignored.
`timescale 1ns/10ps
`default_nettype none
module scr_regs #(
  parameter int RESET_CYCLES = scr_pkg::RESET_CYCLES
) (
  // Clock and reset
  input wire logic clk_i,
  input wire logic reset_n_i,
  // Register port
  input wire logic [scr_pkg::ADDR_W-1:0] addr_i,
  input wire logic wr_i,
  input wire logic [scr_pkg::DATA_W-1:0] wdata_i,
  input wire logic rd_i,
  output logic [scr_pkg::DATA_W-1:0] rdata_o,
  output logic rvalid_o,
  // Configuration outputs
  output logic addr_up_o,
  output logic separate_output_flag_o,
  output logic [scr_pkg::MODE_W-1:0] mode_o,
  output logic power_down_o,
  output logic chip_reset_o
);
  import scr_pkg::*;

  logic rst_s1_reg, rst_s2_reg, rst_n;
  logic [7:0] cfg_reg;
  logic [7:0] opst_reg;
  logic [7:0] part_reg;
  logic start_reg;
  logic chip_reset_reg;
  logic [7:0] rd_next;
  scr_if ctl ();

  function automatic logic hit(input logic [ADDR_W-1:0] a,
                               input logic [ADDR_W-1:0] ofs);
    hit = (a == ofs);
  endfunction

  always_ff @(posedge clk_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      rst_s1_reg <= 1'b0;
      rst_s2_reg <= 1'b0;
    end else begin
      rst_s1_reg <= 1'b1;
      rst_s2_reg <= rst_s1_reg;
    end
  end
  assign rst_n = rst_s2_reg;

  scr_reset_timer #(.CYCLES(RESET_CYCLES)) u_timer (
    .clk_i(clk_i),
    .rst_n(rst_n),
    .ctl(ctl)
  );

  // Full reset request, one-cycle pulse into the timer
  always_ff @(posedge clk_i or negedge rst_n) begin
    if (!rst_n) begin
      start_reg <= 1'b0;
    end else begin
      start_reg <= wr_i && !ctl.busy && !start_reg &&
                   hit(addr_i, OFS_INTERFACE_CONFIG) &&
                   wdata_i[BIT_FULL_RESET]; // RQ1
    end
  end
  assign ctl.start = start_reg;

  // Chip reset spans the request cycle and the whole interval
  always_ff @(posedge clk_i or negedge rst_n) begin
    if (!rst_n) begin
      chip_reset_reg <= 1'b0;
    end else begin
      chip_reset_reg <= start_reg || ctl.busy; // RQ1
    end
  end

  // Register writes; during the reset interval everything is held at reset
  // values, so stray traffic then is lost rather than half applied.
  always_ff @(posedge clk_i or negedge rst_n) begin
    if (!rst_n) begin
      cfg_reg <= RST_INTERFACE_CONFIG; // RQ7
      opst_reg <= RST_OPERATING_STATE;
      part_reg <= RST_PART_CLASS_HI;
    end else if (start_reg || ctl.busy) begin
      cfg_reg <= RST_INTERFACE_CONFIG; // RQ1 RQ2 RQ3
      opst_reg <= RST_OPERATING_STATE;
      part_reg <= RST_PART_CLASS_HI;
    end else if (wr_i) begin
      if (hit(addr_i, OFS_INTERFACE_CONFIG)) begin
        cfg_reg <= (wdata_i & MASK_CFG_RW) |
                   (RST_INTERFACE_CONFIG & ~MASK_CFG_RW); // RQ4 RQ5 RQ8
      end
      if (hit(addr_i, OFS_OPERATING_STATE)) begin
        opst_reg <= wdata_i; // RQ6 RQ8
      end
      if (hit(addr_i, OFS_PART_CLASS)) begin
        part_reg <= wdata_i & MASK_PART_RW; // RQ8
      end
    end
  end

  always_comb begin
    rd_next = ZERO_BYTE;
    if (hit(addr_i, OFS_INTERFACE_CONFIG)) begin
      rd_next = cfg_reg;
      rd_next[BIT_FULL_RESET] = chip_reset_reg; // RQ2
      rd_next[BIT_SEP_OUT] = 1'b1; // RQ5
    end else if (hit(addr_i, OFS_OPERATING_STATE)) begin
      rd_next = opst_reg;
    end else if (hit(addr_i, OFS_PART_CLASS)) begin
      rd_next = {part_reg[7:4], PART_CLASS_CODE};
    end
  end

  // Read data registered; unmapped addresses read zero
  always_ff @(posedge clk_i or negedge rst_n) begin
    if (!rst_n) begin
      rdata_o <= ZERO_BYTE;
      rvalid_o <= 1'b0;
    end else begin
      rvalid_o <= rd_i;
      if (rd_i) begin
        rdata_o <= rd_next;
      end
    end
  end

  // Outputs
  always_ff @(posedge clk_i or negedge rst_n) begin
    if (!rst_n) begin
      addr_up_o <= RST_INTERFACE_CONFIG[BIT_ADDR_UP];
      separate_output_flag_o <= 1'b1;
      mode_o <= MODE_NORMAL;
      power_down_o <= 1'b0;
      chip_reset_o <= 1'b0;
    end else begin
      addr_up_o <= cfg_reg[BIT_ADDR_UP]; // RQ4
      separate_output_flag_o <= 1'b1; // RQ5
      mode_o <= opst_reg[MODE_LSB +: MODE_W]; // RQ6
      power_down_o <= (opst_reg[MODE_LSB +: MODE_W] == MODE_POWER_DOWN);
      chip_reset_o <= chip_reset_reg;
    end
  end
endmodule
`default_nettype wire

// ---- scr_regs_sva.sv ----
// Purpose: Port checker for the configuration register bank
// Assumes: Bench keeps the host quiet during a full reset
// Notes: Reset lengths checked within a small window
`timescale 1ns/10ps
`default_nettype none
module scr_regs_sva #(parameter int RESET_CYCLES = 4) (
  input wire logic clk_i, reset_n_i, wr_i, rd_i,
  input wire logic [14:0] addr_i,
  input wire logic [7:0] wdata_i, rdata_o,
  input wire logic rvalid_o, addr_up_o, separate_output_flag_o,
  input wire logic [1:0] mode_o,
  input wire logic power_down_o, chip_reset_o);
  default clocking @(posedge clk_i); endclocking
  default disable iff (!reset_n_i);
  a_read_answer_time: assert property (rvalid_o == $past(rd_i))
    else $error("read answer late or spurious");
  a_sep_flag_one: assert property (separate_output_flag_o)
    else $error("separate output flag low");
  a_cfg_bit_four: assert property (
    rvalid_o && $past(addr_i) == 15'h0 |-> rdata_o[4])
    else $error("bit four read as zero");
  a_power_down_map: assert property (power_down_o == (mode_o == 2'h3))
    else $error("power down does not match mode");
  a_full_reset_start: assert property (
    wr_i && addr_i == 15'h0 && wdata_i[7] && !chip_reset_o
    |-> ##3 chip_reset_o)
    else $error("full reset not started");
  a_reset_self_clear: assert property (
    $rose(chip_reset_o) |-> chip_reset_o[*3] ##[1:3] !chip_reset_o)
    else $error("full reset length wrong");
  a_reset_defaults: assert property (
    $fell(chip_reset_o) |-> addr_up_o && mode_o == 2'h0)
    else $error("not back to reset");
  a_dir_write: assert property (
    wr_i && addr_i == 15'h0 && !wdata_i[7] && !chip_reset_o
    |-> ##2 addr_up_o == $past(wdata_i[5], 2))
    else $error("direction not updated");
  a_mode_write: assert property (
    wr_i && addr_i == 15'h2 && !chip_reset_o
    |-> ##2 mode_o == $past(wdata_i[1:0], 2))
    else $error("mode not updated");
endmodule
bind scr_regs scr_regs_sva #(.RESET_CYCLES(RESET_CYCLES)) scr_regs_sva_inst (.*);
`default_nettype wire

// ---- scr_host.sv ----
// Purpose: Serial host model issuing single register accesses
// Assumes: Design answers reads one cycle later
// Notes: Released data shows the inverse to catch stale sampling
`timescale 1ns/10ps
`default_nettype none
module scr_host #(parameter int W = 8) (
  input wire logic clk_i,
  output logic [14:0] addr_o,
  output logic wr_o, rd_o,
  output logic [7:0] wdata_o);
  initial begin
    addr_o = 15'h0;
    wr_o = 1'b0;
    rd_o = 1'b0;
    wdata_o = 8'h0;
  end
  task automatic wr(input logic [14:0] a, input logic [7:0] d);
    @(posedge clk_i) #1 addr_o = a;
    wdata_o = d;
    wr_o = 1'b1;
    @(posedge clk_i) #1 wr_o = 1'b0;
    wdata_o = ~d;
    if (a == 15'h0 && d[7]) repeat (W) @(posedge clk_i);
  endtask
  task automatic rd(input logic [14:0] a);
    @(posedge clk_i) #1 addr_o = a;
    rd_o = 1'b1;
    @(posedge clk_i) #1 rd_o = 1'b0;
    addr_o = ~a;
  endtask
endmodule
`default_nettype wire

// ---- testbench.sv ----
// Purpose: Self-checking bench for the configuration register bank
// Assumes: Short full-reset interval for simulation
// Notes: Read results checked from a queue of expectations
`timescale 1ns/10ps
`default_nettype none
module testbench;
  import scr_pkg::*;
  logic clk_i = 0, reset_n_i = 0, wr_i, rd_i, rvalid_o, addr_up_o;
  logic separate_output_flag_o, power_down_o, chip_reset_o;
  logic [14:0] addr_i;
  logic [7:0] wdata_i, rdata_o, v, r, c;
  logic [1:0] mode_o;
  int errors = 0, num_checks = 0, seed = 32'hd559;
  logic [7:0] q[$];
  `define CHK(a, e) begin num_checks++; if ((a) !== (e)) begin errors++; \
    $display("[FAIL] %0t got %h exp %h", $time, a, e); end end
  always #5 clk_i = ~clk_i;
  scr_regs #(.RESET_CYCLES(4)) scr_regs_inst (.*);
  scr_host #(.W(8)) scr_host_inst (.clk_i(clk_i), .addr_o(addr_i),
    .wr_o(wr_i), .rd_o(rd_i), .wdata_o(wdata_i));
  always @(negedge clk_i) if (rvalid_o === 1'b1) begin
    v = q.pop_front();
    `CHK(rdata_o, v)
  end
  task rd(input logic [14:0] a, input logic [7:0] e);
    q.push_back(e);
    scr_host_inst.rd(a);
  endtask
  task results;
    if (errors == 0 && num_checks > 0) $display("DONE - PASS");
    else $display("DONE - FAIL");
    $finish;
  endtask
  initial begin
    repeat (16) @(posedge clk_i);
    #1 reset_n_i = 1;
    repeat (3) @(posedge clk_i);
    rd(OFS_INTERFACE_CONFIG, RST_INTERFACE_CONFIG);
    rd(OFS_OPERATING_STATE, RST_OPERATING_STATE);
    rd(OFS_PART_CLASS, {4'h0, PART_CLASS_CODE});
    rd(15'h0001, ZERO_BYTE);
    for (int i = 0; i < 4; i++) begin
      r = $random(seed);
      c = {1'b0, r[6], i[0], 1'b1, r[3:0]};
      scr_host_inst.wr(OFS_OPERATING_STATE, {r[7:2], i[1:0]});
      scr_host_inst.wr(OFS_INTERFACE_CONFIG, {1'b0, r[6], i[0], r[4:0]});
      rd(OFS_OPERATING_STATE, {r[7:2], i[1:0]});
      rd(OFS_INTERFACE_CONFIG, c);
      `CHK(addr_up_o, i[0])
      `CHK(mode_o, i[1:0])
      `CHK(power_down_o, (i[1:0] == 2'h3))
    end
    scr_host_inst.wr(OFS_INTERFACE_CONFIG, 8'h80);
    rd(OFS_INTERFACE_CONFIG, RST_INTERFACE_CONFIG);
    rd(OFS_OPERATING_STATE, RST_OPERATING_STATE);
    `CHK(mode_o, MODE_NORMAL)
    repeat (3) @(posedge clk_i);
    results();
  end
  initial begin
    #20000 errors++;
    results();
  end
endmodule
`default_nettype wire
